// ### verilog/gpe_map.vh
`ifndef GPE_MAP_VH
`define GPE_MAP_VH

// ==================================================
// Data memory map
`define GPE_AW 9
`define GPE_ADDR_PORT_BASE 9'h020
`define GPE_ADDR_PORT_LAST 9'h03A
`define GPE_ADDR_PA_IN 9'h020
`define GPE_ADDR_PA_OUT 9'h021
`define GPE_ADDR_PA_DIR 9'h022
`define GPE_ADDR_PB_EDGE 9'h017
`define GPE_ADDR_PB_FLAG 9'h018
`define GPE_ADDR_PB_IEN 9'h019

// ==================================================
// Port layout
`define GPE_NPORTS 7
`define GPE_PORT_STRIDE 3
`define GPE_PA_WIDTH 4
`define GPE_PB_LSB 8

// ==================================================
// Register kinds inside one port triple
`define GPE_KIND_IN 2'h0
`define GPE_KIND_OUT 2'h1
`define GPE_KIND_DIR 2'h2

// ==================================================
// Reset values
`define GPE_DIR_RST 8'hFF
`define GPE_OUT_RST 8'h00
`define GPE_EDGE_RST 8'h00
`define GPE_IEN_RST 8'h00

// ==================================================
// Timing
`define GPE_CLR_DLY 2'h2
`define GPE_HIDE_W 2

`endif

// ### verilog/gpe_edge_flags.v
`timescale 1ns/100ps
`default_nettype none

// ==================================================
// Clockless edge catchers for the eight interrupt pins
module gpe_edge_flags (
  input wire mclk,
  input wire rst_n,
  input wire [7:0] pin_in,
  input wire [7:0] edge_sel,
  input wire [7:0] clr_take,
  output wire [7:0] raw_flag,
  output wire [7:0] flag_seen
);

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_pin
      wire trig;
      reg set_t_r;
      reg clr_t_r;
      reg set_s1_r;
      reg set_s2_r;
      reg flg_s1_r;
      reg flg_s2_r;

      // Inverting selects the falling edge; a change of select may itself fire
      assign trig = pin_in[i] ^ edge_sel[i];

      // Pin edge clocks the cell, so it works with mclk stopped
      always @(posedge trig or negedge rst_n)
      begin
        if (!rst_n)
          set_t_r <= 1'b0;
        else
          set_t_r <= ~clr_t_r;
      end

      // Clear copies the synced set side; a newer edge keeps the flag
      always @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          clr_t_r <= 1'b0;
          set_s1_r <= 1'b0;
          set_s2_r <= 1'b0;
          flg_s1_r <= 1'b0;
          flg_s2_r <= 1'b0;
        end
        else
        begin
          set_s1_r <= set_t_r;
          set_s2_r <= set_s1_r;
          flg_s1_r <= set_t_r ^ clr_t_r;
          flg_s2_r <= flg_s1_r;
          if (clr_take[i])
            clr_t_r <= set_s2_r;
        end
      end

      assign raw_flag[i] = set_t_r ^ clr_t_r;
      assign flag_seen[i] = flg_s2_r;
    end
  endgenerate

endmodule // gpe_edge_flags

`default_nettype wire

// ### verilog/gpe_ports.v
`include "gpe_map.vh"
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Port input, output and direction registers sit in data memory 0x020 to 0x03A.
// - Port B interrupt registers sit at data addresses 0x017 to 0x019.
// - Input register reads return live pin states and ignore writes.
// - With the sync fuse bit clear, input reads come through a sync stage.
// - The output buffer drives the output pins; its reads return the written value.
// - Direction bit clear makes an output; set makes a driverless input.
// - Port A uses four direction bits; its input reads zero above bit 3.
// - Port A output buffer is at 0x021, direction at 0x022.
// - Output writes to input pins are kept and driven once made outputs.
// - Edge select set means falling edge, clear means rising edge.
// - Selected edge sets the pin flag even when its enable is clear.
// - Edge detection and flag setting work with the system clock stopped.
// - A flag clears two cycles after the clearing write.
// - Enable set lets a pin request interrupts; clear stops it.
// - All direction registers reset to ones, every pin a high-impedance input.
// - One 4-bit port A and six 8-bit ports B to G.
module gpe_ports (
  input wire mclk,
  input wire nrst,
  input wire [8:0] dm_addr,
  input wire dm_we,
  input wire dm_re,
  input wire [7:0] dm_wdata,
  output wire [7:0] dm_rdata,
  output wire dm_hit,
  input wire first_fuse_word_sync,
  input wire [3:0] pa_in,
  output wire [3:0] pa_out,
  output wire [3:0] pa_oe,
  input wire [47:0] pbg_in,
  output wire [47:0] pbg_out,
  output wire [47:0] pbg_oe,
  output wire ext_irq
);

  // ==================================================
  // Reset release
  reg rst_s1_r;
  reg rst_n_r;
  wire rst_n;

  // Assert at once, release two clocks later to avoid recovery races
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  assign rst_n = rst_n_r;

  // ==================================================
  // Address decoding
  // Returns {hit, kind[1:0], port[2:0]} for the port triples
  function [5:0] gpe_dec;
    input [8:0] a;
    integer k;
    begin
      gpe_dec = 6'h00;
      for (k = 0; k < `GPE_NPORTS; k = k + 1)
      begin
        if (a == `GPE_ADDR_PORT_BASE + `GPE_PORT_STRIDE * k)
          gpe_dec = {1'b1, `GPE_KIND_IN, k[2:0]};
        if (a == `GPE_ADDR_PORT_BASE + `GPE_PORT_STRIDE * k + 1)
          gpe_dec = {1'b1, `GPE_KIND_OUT, k[2:0]};
        if (a == `GPE_ADDR_PORT_BASE + `GPE_PORT_STRIDE * k + 2)
          gpe_dec = {1'b1, `GPE_KIND_DIR, k[2:0]};
      end
    end
  endfunction

  // Returns {hit, select[1:0]} for the three port B interrupt registers
  function [2:0] gpe_dec_int;
    input [8:0] a;
    begin
      case (a)
        `GPE_ADDR_PB_EDGE: gpe_dec_int = 3'h4;
        `GPE_ADDR_PB_FLAG: gpe_dec_int = 3'h5;
        `GPE_ADDR_PB_IEN: gpe_dec_int = 3'h6;
        default: gpe_dec_int = 3'h0;
      endcase
    end
  endfunction

  wire [5:0] dec;
  wire dec_hit;
  wire [1:0] dec_kind;
  wire [2:0] dec_port;
  wire [5:0] dec_base;
  wire [2:0] idec;
  wire [1:0] isel;
  wire int_hit;
  wire wr_port;
  wire wr_edge;
  wire wr_flag;
  wire wr_ien;

  // Port triples laid out from the base, port A first
  assign dec = gpe_dec(dm_addr);
  assign dec_hit = dec[5];
  assign dec_kind = dec[4:3];
  assign dec_port = dec[2:0];
  assign dec_base = {dec_port, 3'h0};
  assign idec = gpe_dec_int(dm_addr);
  assign int_hit = idec[2];
  assign isel = idec[1:0];
  assign wr_port = dm_we & dec_hit;
  assign wr_edge = dm_we & int_hit & (isel == 2'h0);
  assign wr_flag = dm_we & int_hit & (isel == 2'h1);
  assign wr_ien = dm_we & int_hit & (isel == 2'h2);

  // ==================================================
  // Pin sampling
  wire [55:0] pins;
  reg [55:0] sync1_r;
  reg [55:0] sync2_r;

  // Port A fills only the low nibble of its slot
  assign pins = {pbg_in, 4'h0, pa_in};

  // Two stages guard against metastable inputs; reads lag the pins
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= 56'h0;
      sync2_r <= 56'h0;
    end
    else
    begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  // ==================================================
  // Output buffer and direction registers
  reg [55:0] out_r;
  reg [55:0] dir_r;
  reg [55:0] oe_r;

  genvar p;
  generate
    for (p = 0; p < `GPE_NPORTS; p = p + 1)
    begin : g_port
      // Output data is stored whatever the direction
      always @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          out_r[p*8 +: 8] <= `GPE_OUT_RST;
        else if (wr_port && dec_port == p && dec_kind == `GPE_KIND_OUT)
          out_r[p*8 +: 8] <= dm_wdata;
      end

      // Enable copy kept beside the direction so pins leave a flop
      always @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          dir_r[p*8 +: 8] <= `GPE_DIR_RST;
          oe_r[p*8 +: 8] <= ~`GPE_DIR_RST;
        end
        else if (wr_port && dec_port == p && dec_kind == `GPE_KIND_DIR)
        begin
          dir_r[p*8 +: 8] <= dm_wdata;
          oe_r[p*8 +: 8] <= ~dm_wdata;
        end
      end
    end
  endgenerate

  // Port A upper direction bits are stored but drive nothing
  assign pa_out = out_r[`GPE_PA_WIDTH-1:0];
  assign pa_oe = oe_r[`GPE_PA_WIDTH-1:0];
  assign pbg_out = out_r[55:8];
  assign pbg_oe = oe_r[55:8];

  // ==================================================
  // Port B interrupt registers
  reg [7:0] edge_r;
  reg [7:0] ien_r;
  reg [`GPE_HIDE_W-1:0] hide_r [0:7];
  reg [7:0] flag_r;
  reg [7:0] clr_pend_r;
  wire [7:0] clr_take;
  wire [7:0] raw_flag;
  wire [7:0] flag_seen;

  // Edge select and enables are plain read/write bytes
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      edge_r <= `GPE_EDGE_RST;
      ien_r <= `GPE_IEN_RST;
    end
    else
    begin
      if (wr_edge)
        edge_r <= dm_wdata;
      if (wr_ien)
        ien_r <= dm_wdata;
    end
  end

  // Writing zero to a set flag clears it; writing one leaves it
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      clr_pend_r <= 8'h00;
    else if (wr_flag)
      clr_pend_r <= ~dm_wdata & flag_r;
    else
      clr_pend_r <= 8'h00;
  end

  assign clr_take = clr_pend_r;

  // Edges go straight in from the pad, not through the sync stage
  gpe_edge_flags u_edge_flags (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_in(pins[`GPE_PB_LSB +: 8]),
    .edge_sel(edge_r),
    .clr_take(clr_take),
    .raw_flag(raw_flag),
    .flag_seen(flag_seen)
  );

  genvar f;
  generate
    for (f = 0; f < 8; f = f + 1)
    begin : g_flag
      // Synced flag lags its cell; hide the stale copy after a clear
      always @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          hide_r[f] <= {`GPE_HIDE_W{1'b0}};
          flag_r[f] <= 1'b0;
        end
        else if (clr_take[f])
        begin
          hide_r[f] <= `GPE_CLR_DLY;
          flag_r[f] <= 1'b0;
        end
        else if (hide_r[f] != {`GPE_HIDE_W{1'b0}})
        begin
          hide_r[f] <= hide_r[f] - 1'b1;
          flag_r[f] <= 1'b0;
        end
        else
          flag_r[f] <= flag_seen[f];
      end
    end
  endgenerate

  // ==================================================
  // Interrupt request
  reg irq_r;

  // Held until software clears the flag or the enable
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq_r <= 1'b0;
    else
      irq_r <= |(flag_r & ien_r);
  end

  assign ext_irq = irq_r;

  // ==================================================
  // Read path
  reg [7:0] rd_nxt;
  reg [7:0] rdata_r;
  reg hit_r;

  // Input reads pick direct pins or the synced copy per the fuse bit
  always @*
  begin
    rd_nxt = 8'h00;
    if (dec_hit)
    begin
      case (dec_kind)
        `GPE_KIND_IN:
        begin
          if (first_fuse_word_sync)
            rd_nxt = pins[dec_base +: 8];
          else
            rd_nxt = sync2_r[dec_base +: 8];
        end
        `GPE_KIND_OUT: rd_nxt = out_r[dec_base +: 8];
        `GPE_KIND_DIR: rd_nxt = dir_r[dec_base +: 8];
        default: rd_nxt = 8'h00;
      endcase
    end
    else if (int_hit)
    begin
      case (isel)
        2'h0: rd_nxt = edge_r;
        2'h1: rd_nxt = flag_r;
        2'h2: rd_nxt = ien_r;
        default: rd_nxt = 8'h00;
      endcase
    end
  end

  // Read data holds until the next read; unmapped reads give zero
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_r <= 8'h00;
      hit_r <= 1'b0;
    end
    else
    begin
      hit_r <= (dm_we | dm_re) & (dec_hit | int_hit);
      if (dm_re)
        rdata_r <= rd_nxt;
    end
  end

  assign dm_rdata = rdata_r;
  assign dm_hit = hit_r;

endmodule // gpe_ports

`default_nettype wire

// ### verif/gpe_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// Far side of the pins
module gpe_pin_model (
  input wire logic [51:0] oe,
  input wire logic [51:0] drv,
  input wire logic [51:0] ext,
  output logic [51:0] pins
);
  // Driven pins show the buffer, others the outside part, so none floats
  assign pins = (oe & drv) | (~oe & ext);
endmodule // gpe_pin_model
`default_nettype wire

// ### verif/gpe_ports_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// Bus and pin checks
module gpe_chk (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [8:0] dm_addr,
  input wire logic dm_we,
  input wire logic dm_re,
  input wire logic [7:0] dm_wdata,
  input wire logic [7:0] dm_rdata,
  input wire logic dm_hit,
  input wire logic [3:0] pa_out,
  input wire logic [3:0] pa_oe,
  input wire logic [47:0] pbg_oe,
  input wire logic ext_irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // Any bus access
  wire logic acc = dm_we | dm_re;
  chk_dir_oe: assert property (dm_we && dm_addr == 9'h022 |=> pa_oe == ~$past(dm_wdata[3:0]))
    else $error("oe not from direction");
  chk_out_pin: assert property (dm_we && dm_addr == 9'h021 |=> pa_out == $past(dm_wdata[3:0]))
    else $error("pin not from buffer");
  // Seven triples end at 0x034; the rest of the window up to 0x03A is left unmapped
  chk_map_hit: assert property (acc && dm_addr >= 9'h020 && dm_addr <= 9'h034 |=> dm_hit)
    else $error("port access missed");
  chk_intr_hit: assert property (acc && dm_addr >= 9'h017 && dm_addr <= 9'h019 |=> dm_hit)
    else $error("interrupt access missed");
  chk_unmap_miss: assert property (acc && dm_addr > 9'h03A |=> !dm_hit && (!$past(dm_re) || dm_rdata == 8'h00))
    else $error("unmapped access answered");
  chk_pa_high: assert property (dm_re && dm_addr == 9'h020 |=> dm_rdata[7:4] == 4'h0)
    else $error("port A high bits set");
  chk_oe_hold: assert property (!dm_we |=> $stable(pbg_oe) && $stable(pa_oe))
    else $error("oe moved without write");
  chk_irq_off: assert property (dm_we && dm_addr == 9'h019 && dm_wdata == 8'h00 |=> ##1 !ext_irq)
    else $error("irq with enables clear");
endmodule // gpe_chk
bind gpe_ports gpe_chk gpe_chk_inst (.mclk, .nrst, .dm_addr, .dm_we, .dm_re, .dm_wdata, .dm_rdata, .dm_hit,
  .pa_out, .pa_oe, .pbg_oe, .ext_irq);
`default_nettype wire

// ### verif/gpe_ports_edge_interrupts_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
// ==================================================
// Bench
module gpe_ports_edge_interrupts_test;
  logic mclk = 1'b0;
  logic run = 1'b1;
  logic nrst = 1'b0;
  logic fuse = 1'b1;
  logic dm_we = 1'b0;
  logic dm_re = 1'b0;
  logic [8:0] dm_addr = 9'h000;
  logic [7:0] dm_wdata = 8'h00;
  logic [51:0] ext = 52'h0;
  wire logic [51:0] pins;
  wire logic [7:0] dm_rdata;
  wire logic dm_hit;
  wire logic ext_irq;
  wire logic [3:0] pa_out;
  wire logic [3:0] pa_oe;
  wire logic [47:0] pbg_out;
  wire logic [47:0] pbg_oe;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] seed = 32'hBC88B7E8;
  logic [7:0] out_m [7];
  logic [7:0] dir_m [7];
  logic [7:0] es, m, ien, v;
  gpe_ports gpe_ports_inst (.mclk, .nrst, .dm_addr, .dm_we, .dm_re, .dm_wdata, .dm_rdata, .dm_hit,
    .first_fuse_word_sync(fuse), .pa_in(pins[3:0]), .pa_out, .pa_oe, .pbg_in(pins[51:4]), .pbg_out,
    .pbg_oe, .ext_irq);
  gpe_pin_model gpe_pin_model_inst (.oe({pbg_oe, pa_oe}), .drv({pbg_out, pa_out}), .ext, .pins);
  // Clock may be parked to show the catchers need none
  initial forever #12.5 if (run) mclk = ~mclk;
  // Hang guard, far above the few hundred cycles used
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc > 3000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  // ==================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [8:0] ad(input int n, input int k);
    return 9'h020 + 9'(3 * n + k);
  endfunction
  // Expected pin level: buffer where driven, outside part elsewhere
  function automatic logic [7:0] pinv(input int n);
    logic [7:0] e;
    e = (n == 0) ? {4'h0, ext[3:0]} : ext[n * 8 - 4 +: 8];
    e = (out_m[n] & ~dir_m[n]) | (e & dir_m[n]);
    return (n == 0) ? {4'h0, e[3:0]} : e;
  endfunction
  // Strobe dropped a cycle later, so accesses never run back to back
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge mclk);
    dm_addr <= a;
    dm_wdata <= d;
    dm_we <= 1'b1;
    @(posedge mclk);
    dm_we <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e, input logic h);
    @(posedge mclk);
    dm_addr <= a;
    dm_re <= 1'b1;
    @(posedge mclk);
    dm_re <= 1'b0;
    #1;
    `CHK(dm_rdata, e)
    `CHK(dm_hit, h)
  endtask
  task automatic pa_rd(input logic f, input logic [3:0] p, input logic [7:0] e);
    @(posedge mclk);
    fuse <= f;
    ext[3:0] <= p;
    rd(9'h020, e, 1'b1);
  endtask
  // Toggle port B pins in m, optionally with the clock parked
  task automatic flip(input logic s);
    @(negedge mclk);
    run = !s;
    ext[11:4] = ext[11:4] ^ m;
    #100 run = 1'b1;
    repeat (4) @(posedge mclk);
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ==================================================
  // Main sequence
  initial
  begin
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int n = 0; n < 7; n++)
    begin
      out_m[n] = 8'h00;
      dir_m[n] = 8'hFF;
      rd(ad(n, 1), 8'h00, 1'b1);
      rd(ad(n, 2), 8'hFF, 1'b1);
    end
    `CHK({pbg_oe, pa_oe}, 52'h0)
    pa_rd(1'b0, 4'hA, 8'h00);
    rd(9'h020, 8'h0A, 1'b1);
    pa_rd(1'b1, 4'h5, 8'h05);
    @(posedge mclk);
    ext <= 52'({rnd(), rnd()});
    for (int n = 0; n < 7; n++)
    begin
      v = 8'(rnd());
      wr(ad(n, 1), v);
      out_m[n] = v;
      wr(ad(n, 0), 8'(rnd()));
      rd(ad(n, 0), pinv(n), 1'b1);
      v = 8'(rnd());
      wr(ad(n, 2), v);
      dir_m[n] = v;
      rd(ad(n, 1), out_m[n], 1'b1);
      rd(ad(n, 2), v, 1'b1);
      rd(ad(n, 0), pinv(n), 1'b1);
      `CHK(n ? pbg_oe[n * 8 - 8 +: 8] : {4'h0, pa_oe}, n ? ~v : {4'h0, ~v[3:0]})
      `CHK(n ? pbg_out[n * 8 - 8 +: 8] : {4'h0, pa_out}, n ? out_m[n] : {4'h0, out_m[0][3:0]})
    end
    rd(9'h03B, 8'h00, 1'b0);
    rd(9'h1FF, 8'h00, 1'b0);
    wr(9'h025, 8'hFF);
    es = 8'(rnd());
    @(posedge mclk);
    ext[11:4] <= es;
    wr(9'h017, es);
    rd(9'h017, es, 1'b1);
    wr(9'h018, 8'h00);
    rd(9'h018, 8'h00, 1'b1);
    m = 8'(rnd()) | 8'h01;
    flip(1'b0);
    rd(9'h018, m, 1'b1);
    `CHK(ext_irq, 1'b0)
    wr(9'h018, 8'h00);
    flip(1'b0);
    rd(9'h018, 8'h00, 1'b1);
    ien = 8'(rnd()) | 8'h01;
    wr(9'h019, ien);
    rd(9'h019, ien, 1'b1);
    flip(1'b1);
    rd(9'h018, m, 1'b1);
    `CHK(ext_irq, |(m & ien))
    wr(9'h018, 8'hFE);
    repeat (3) @(posedge mclk);
    #1;
    `CHK(ext_irq, |(m & ien & 8'hFE))
    rd(9'h018, m & 8'hFE, 1'b1);
    wr(9'h019, 8'h00);
    repeat (2) @(posedge mclk);
    #1;
    `CHK(ext_irq, 1'b0)
    wrap_up();
  end
endmodule // gpe_ports_edge_interrupts_test
`default_nettype wire
